// ==== verilog/host_select_power_handshake.sv ====
`timescale 1ns/1ps
// Function
// [R01] Three straps decode to host interface.
// [R02] Open strap reads high, latched after reset.
// [R03] Host never drives straps actively.
// [R04] Serial host selected maps four serial pins.
// [R05] Sleep indicator low during any sleep; code drives it low only with pin handshake on.
// [R06] Deep sleep indicator low during deep.
// [R07] Deep wake input high leaves deep.
// [R08] Bypass pin high after boot wakes light.
// [R09] Bypass during boot ignores host, loads flash.
// [R10] Supply enable low during deep sleep.
// [R11] Host wake output, configurable polarity.
// [R12] Host wake only when interrupt unusable.
// [R13] Coex mode: transmit active output high.
// [R14] Coex mode: peer priority input honoured.
// [R15] Coex mode: peer active input honoured.
// [R16] Audio slave mode on shared pins.
// [R17] Debug serial port on two pins.
// [R18] Unused pins switchable to output.
// [R19] Two-wire clock in, data bidirectional.
// [R20] Host holds wake until indicator high.
// [R21] Async active-low reset, 20 ms minimum.
// [R22] Deep sleep by packet or pin handshake; code enters deep sleep by packet only.
module host_select_power_handshake (
	// Clock, reset and enable.
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic clk_en_i,
	// Bootstrap pins, open reads as one.
	input wire logic [2:0] straps_i,
	output pin_ctrl_pkg::host_if_t host_if_o,
	// Boot loader state and bypass.
	input wire logic boot_loading_i,
	input wire logic loader_bypass_in_i,
	output logic ignore_host_o,
	output logic load_default_fw_o,
	// Sleep control from firmware or host packets.
	input wire logic pin_handshake_en_i,
	input wire logic pkt_sleep_req_i,
	input wire logic pkt_deep_req_i,
	input wire logic pkt_wake_i,
	input wire logic deep_sleep_wake_in_i,
	output logic sleep_indicator_o,
	output logic deep_sleep_indicator_o,
	output logic supply_enable_out_o,
	output logic light_sleep_o,
	output logic deep_sleep_o,
	// Host wake-up.
	input wire logic host_wake_en_i,
	input wire logic host_wake_active_high_i,
	input wire logic pkt_pending_i,
	output logic host_wake_o,
	// Shared pin mode and radio coexistence.
	input wire pin_ctrl_pkg::pin_mode_t pin_mode_i,
	input wire logic wlan_tx_i,
	input wire logic peer_priority_in_i,
	input wire logic peer_tx_active_in_i,
	output logic radio_tx_active_out_o,
	output logic tx_grant_o,
	// Host serial pins.
	input wire logic host_serial_rx_i,
	input wire logic host_serial_cts_i,
	input wire logic uart_tx_i,
	input wire logic uart_rts_i,
	output logic host_serial_tx_o,
	output logic host_serial_rts_o,
	output logic uart_rx_o,
	output logic uart_cts_o,
	// Debug serial pins.
	input wire logic debug_serial_rx_i,
	input wire logic dbg_tx_i,
	output logic debug_serial_tx_o,
	output logic dbg_rx_o,
	// Audio serial slave.
	input wire logic audio_bclk_i,
	input wire logic audio_ws_i,
	input wire logic audio_din_i,
	input wire logic audio_dout_i,
	output logic audio_dout_o,
	output logic audio_bclk_o,
	output logic audio_ws_o,
	output logic audio_din_o,
	// Two-wire interface.
	input wire logic i2c_en_i,
	input wire logic i2c_scl_i,
	input wire logic i2c_sda_i,
	input wire logic i2c_sda_low_i,
	output logic i2c_scl_o,
	output logic i2c_sda_o,
	output logic i2c_sda_oe_o,
	output logic i2c_sda_in_o,
	// Spare general-purpose pins.
	input wire logic gpio_dir_we_i,
	input wire logic [pin_ctrl_pkg::GPIO_W-1:0] gpio_dir_wdata_i,
	output logic [pin_ctrl_pkg::GPIO_W-1:0] gpio_oe_o,
	output logic [pin_ctrl_pkg::GPIO_W-1:0] gpio_out_o
);
	import pin_ctrl_pkg::*;

	logic strap_done_q;
	host_if_t host_if_q;
	logic uart_sel;
	logic audio_sel;
	logic coex_sel;
	logic wake_pulse;
	logic [GPIO_W-1:0] gpio_dir_q;
	logic sleep_ind_q;
	logic deep_ind_q;
	logic supply_q;
	logic host_wake_q;
	logic radio_tx_q;
	logic grant_q;
	logic ignore_q;
	logic dout_q;
	logic sda_in_q;
	pwr_if pw ();

	// Straps are caught on the first enabled edge after release, never
	// under reset itself, so the async reset only loads constants.
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			strap_done_q <= 1'b0; // see [R21]
			host_if_q <= HOST_SDIO;
		end else if (clk_en_i && !strap_done_q) begin
			strap_done_q <= 1'b1; // see [R02]
			host_if_q <= decode_straps(straps_i); // see [R01]
		end
	end
	assign host_if_o = host_if_q;

	assign uart_sel = (host_if_q == HOST_UART);
	assign audio_sel = (pin_mode_i == PIN_AUDIO);
	assign coex_sel = (pin_mode_i == PIN_COEX);

	// Serial host pins only act once the serial host interface is chosen.
	always_comb begin
		host_serial_tx_o = uart_sel ? uart_tx_i : 1'b0; // see [R04]
		host_serial_rts_o = uart_sel ? uart_rts_i : 1'b0;
		uart_rx_o = uart_sel ? host_serial_rx_i : 1'b1;
		uart_cts_o = uart_sel ? host_serial_cts_i : 1'b0;
	end

	// Debug serial receive passes straight through.
	assign dbg_rx_o = debug_serial_rx_i; // see [R17]

	// Audio slave: clock, word select and data come in, data goes out.
	always_comb begin
		audio_bclk_o = audio_sel & audio_bclk_i; // see [R16]
		audio_ws_o = audio_sel & audio_ws_i;
		audio_din_o = audio_sel & audio_din_i;
		i2c_scl_o = i2c_en_i & i2c_scl_i; // see [R19]
	end

	// Shared transmit pin: audio data wins over the debug port.
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dout_q <= 1'b1;
		end else if (clk_en_i) begin
			dout_q <= audio_sel ? audio_dout_i : dbg_tx_i; // see [R16]
		end
	end
	assign audio_dout_o = dout_q;
	assign debug_serial_tx_o = dout_q; // see [R17]

	// Open-drain data line: drive only while pulling low.
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sda_in_q <= 1'b1;
		end else if (clk_en_i) begin
			sda_in_q <= i2c_sda_i;
		end
	end
	assign i2c_sda_o = 1'b0;
	assign i2c_sda_oe_o = i2c_en_i & i2c_sda_low_i; // see [R19]
	assign i2c_sda_in_o = sda_in_q;

	// Spare pins default to inputs; a command turns them to outputs.
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			gpio_dir_q <= GPIO_DIR_RST;
		end else if (clk_en_i && gpio_dir_we_i) begin
			gpio_dir_q <= gpio_dir_wdata_i; // see [R18]
		end
	end
	assign gpio_oe_o = gpio_dir_q;
	assign gpio_out_o = '0;

	// Bypass during boot stops host traffic and forces flash load.
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ignore_q <= 1'b0;
		end else if (clk_en_i) begin
			ignore_q <= boot_loading_i & loader_bypass_in_i; // see [R09]
		end
	end
	assign ignore_host_o = ignore_q;
	assign load_default_fw_o = ignore_q;

	// Sleep entry comes by packet only; the pin wakes light sleep when handshake is on.
	assign wake_pulse = pkt_wake_i |
		(pin_handshake_en_i & !boot_loading_i & loader_bypass_in_i);
	assign pw.sleep_req = pkt_sleep_req_i;
	assign pw.deep_req = pkt_deep_req_i; // see [R22]
	assign pw.wake_light = wake_pulse; // see [R08]
	assign pw.wake_deep = deep_sleep_wake_in_i | pkt_wake_i; // see [R07]

	sleep_fsm u_fsm (
		.core_clk_i(core_clk_i),
		.resetn_i(resetn_i),
		.clk_en_i(clk_en_i),
		.p(pw.ctrl)
	);
	assign light_sleep_o = pw.in_light;
	assign deep_sleep_o = pw.in_deep;

	// Indicators follow the state one cycle later from flip-flops.
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sleep_ind_q <= 1'b1;
			deep_ind_q <= 1'b1;
			supply_q <= 1'b1;
		end else if (clk_en_i) begin
			sleep_ind_q <= !(pin_handshake_en_i &
				(pw.in_light | pw.in_deep)); // see [R05]
			deep_ind_q <= !pw.in_deep; // see [R06]
			supply_q <= !pw.in_deep; // see [R10]
		end
	end
	assign sleep_indicator_o = sleep_ind_q;
	assign deep_sleep_indicator_o = deep_ind_q;
	assign supply_enable_out_o = supply_q;

	// Host wake polarity is chosen by software; idle is the inverse.
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			host_wake_q <= 1'b0;
		end else if (clk_en_i) begin
			host_wake_q <= (host_wake_en_i & pkt_pending_i) ~^
				host_wake_active_high_i; // see [R11]
		end
	end
	assign host_wake_o = host_wake_q;

	// Coexistence: own transmit flagged out; peer activity or priority
	// withdraws the grant, trading our throughput for their traffic.
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			radio_tx_q <= 1'b0;
			grant_q <= 1'b1;
		end else if (clk_en_i) begin
			radio_tx_q <= coex_sel & wlan_tx_i; // see [R13]
			grant_q <= !(coex_sel & (peer_priority_in_i |
				peer_tx_active_in_i)); // see [R14] [R15]
		end
	end
	assign radio_tx_active_out_o = radio_tx_q;
	assign tx_grant_o = grant_q;

	// Checks.
	property p_strap_decode;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(clk_en_i && !strap_done_q) |=>
		host_if_q == decode_straps($past(straps_i));
	endproperty
	a_strap_decode: assert property (p_strap_decode) // see [R01]
		else $error("host interface mismatch with straps");
	property p_strap_hold;
		@(posedge core_clk_i) disable iff (!resetn_i)
		strap_done_q |=> $stable(host_if_q);
	endproperty
	a_strap_hold: assert property (p_strap_hold) // see [R02]
		else $error("host interface changed after capture");
	property p_uart_pins;
		@(posedge core_clk_i) disable iff (!resetn_i)
		!uart_sel |-> (host_serial_tx_o == 1'b0 && uart_rx_o == 1'b1);
	endproperty
	a_uart_pins: assert property (p_uart_pins) // see [R04]
		else $error("serial pins active without serial host");
	property p_deep_ind;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(clk_en_i && pw.in_deep) |=> (!deep_ind_q && !supply_q);
	endproperty
	a_deep_ind: assert property (p_deep_ind) // see [R06]
		else $error("deep indicator or supply high in deep");
	property p_supply;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(clk_en_i && !pw.in_deep) |=> supply_q;
	endproperty
	a_supply: assert property (p_supply) // see [R10]
		else $error("supply enable low outside deep sleep");
	property p_sleep_ind;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(clk_en_i && pin_handshake_en_i && pw.in_light) |=> !sleep_ind_q;
	endproperty
	a_sleep_ind: assert property (p_sleep_ind) // see [R05]
		else $error("sleep indicator high in light sleep");
	property p_host_wake;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(clk_en_i && !host_wake_en_i) |=>
		host_wake_q == !$past(host_wake_active_high_i);
	endproperty
	a_host_wake: assert property (p_host_wake) // see [R11]
		else $error("host wake asserted while disabled");
	property p_coex;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(clk_en_i && coex_sel && peer_priority_in_i) |=> !grant_q;
	endproperty
	a_coex: assert property (p_coex) // see [R14]
		else $error("grant kept against peer priority");
	property p_bypass;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(clk_en_i && boot_loading_i && loader_bypass_in_i) |=> ignore_q;
	endproperty
	a_bypass: assert property (p_bypass) // see [R09]
		else $error("bypass during boot not honoured");
	c_deep: cover property (@(posedge core_clk_i) pw.in_deep ##1 !pw.in_deep);
	c_light: cover property (@(posedge core_clk_i) pw.in_light);
	property p_tx_active;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(clk_en_i && coex_sel && wlan_tx_i) |=> radio_tx_q;
	endproperty
	a_tx_active: assert property (p_tx_active) // see [R13]
		else $error("transmit active not flagged in coex mode");
	property p_peer_busy;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(clk_en_i && coex_sel && peer_tx_active_in_i) |=> !grant_q;
	endproperty
	a_peer_busy: assert property (p_peer_busy) // see [R15]
		else $error("grant kept while peer transmits");
	property p_shared_tx;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(clk_en_i && audio_sel) |=> dout_q == $past(audio_dout_i);
	endproperty
	a_shared_tx: assert property (p_shared_tx) // see [R16]
		else $error("audio data out not on shared pin");
	property p_sleep_exit;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(clk_en_i && !pw.in_light && !pw.in_deep) |=> sleep_ind_q;
	endproperty
	a_sleep_exit: assert property (p_sleep_exit) // see [R05]
		else $error("sleep indicator low while awake");
	property p_reset_vals;
		@(posedge core_clk_i)
		!resetn_i |=> (sleep_ind_q && supply_q && !strap_done_q);
	endproperty
	a_reset_vals: assert property (p_reset_vals) // see [R21]
		else $error("outputs not at reset level during reset");
	c_uart: cover property (@(posedge core_clk_i) uart_sel);
	c_bypass: cover property (@(posedge core_clk_i) ignore_q);
endmodule // host_select_power_handshake

// ==== verilog/pin_ctrl_pkg.sv ====
package pin_ctrl_pkg;

	// Decoded host interface selection.
	typedef enum logic [2:0] {
		HOST_SDIO = 3'h0,
		HOST_SPI = 3'h1,
		HOST_USB = 3'h2,
		HOST_USB_CDC = 3'h3,
		HOST_UART = 3'h4,
		HOST_BAD = 3'h7
	} host_if_t;

	// Shared pin function selection.
	typedef enum logic [1:0] {
		PIN_GPIO = 2'h0,
		PIN_AUDIO = 2'h1,
		PIN_COEX = 2'h2
	} pin_mode_t;

	// Power state machine.
	typedef enum logic [1:0] {
		PWR_ACTIVE = 2'h0,
		PWR_LIGHT = 2'h1,
		PWR_DEEP = 2'h2
	} pwr_state_t;

	// Strap vector bit positions: {select0, select1, boot}.
	localparam int STRAP_SEL0 = 2;
	localparam int STRAP_SEL1 = 1;
	localparam int STRAP_BOOT = 0;
	localparam logic [2:0] STRAP_ALL_OPEN = 3'h7;
	localparam int GPIO_W = 16;
	localparam logic [GPIO_W-1:0] GPIO_DIR_RST = 16'h0000;

	// Minimum reset assertion time, milliseconds, and its cycle count.
	localparam int RESET_MIN_MS = 20;
	localparam int CLK_MHZ = 125;
	localparam int RESET_MIN_CYC = RESET_MIN_MS * 1000 * CLK_MHZ;

	// Strap decode used both at capture and by the checks.
	function automatic host_if_t decode_straps(input logic [2:0] s);
		case (s)
			3'h7: decode_straps = HOST_SDIO;
			3'h3: decode_straps = HOST_SPI;
			3'h4: decode_straps = HOST_USB;
			3'h5: decode_straps = HOST_USB_CDC;
			3'h1: decode_straps = HOST_UART;
			default: decode_straps = HOST_BAD;
		endcase
	endfunction

endpackage

// ==== verilog/pwr_if.sv ====
`timescale 1ns/1ps
interface pwr_if;
	logic sleep_req;
	logic deep_req;
	logic wake_light;
	logic wake_deep;
	logic in_light;
	logic in_deep;
	modport ctrl (input sleep_req, deep_req, wake_light, wake_deep,
		output in_light, in_deep);
	modport user (output sleep_req, deep_req, wake_light, wake_deep,
		input in_light, in_deep);
endinterface // pwr_if

// ==== verilog/sleep_fsm.sv ====
`timescale 1ns/1ps
module sleep_fsm (
	// Clock and reset.
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic clk_en_i,
	// Requests and state.
	pwr_if.ctrl p
);
	import pin_ctrl_pkg::*;

	pwr_state_t state_q;

	// Sleep entry from active only; each wake leaves its own state.
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_q <= PWR_ACTIVE;
		end else if (clk_en_i) begin
			case (state_q)
				PWR_ACTIVE: begin
					if (p.deep_req) begin
						state_q <= PWR_DEEP;
					end else if (p.sleep_req) begin
						state_q <= PWR_LIGHT;
					end
				end
				PWR_LIGHT: begin
					if (p.wake_light) begin
						state_q <= PWR_ACTIVE; // see [R08]
					end
				end
				PWR_DEEP: begin
					if (p.wake_deep) begin
						state_q <= PWR_ACTIVE; // see [R07]
					end
				end
				default: state_q <= PWR_ACTIVE;
			endcase
		end
	end

	// State flags are decoded straight from the state register.
	assign p.in_light = (state_q == PWR_LIGHT);
	assign p.in_deep = (state_q == PWR_DEEP);

	property p_deep_exit;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(state_q == PWR_DEEP && p.wake_deep && clk_en_i) |=>
		state_q == PWR_ACTIVE;
	endproperty
	a_deep_exit: assert property (p_deep_exit) // see [R07]
		else $error("deep sleep did not end on wake");
	property p_light_hold;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(state_q == PWR_LIGHT && !p.wake_light) |=>
		state_q == PWR_LIGHT;
	endproperty
	a_light_hold: assert property (p_light_hold) // see [R08]
		else $error("light sleep left without wake");
endmodule // sleep_fsm

// ==== tb/host_model.sv ====
`timescale 1ns/1ps
// Host processor side of the sleep handshake, plus the strap resistors.
module host_model (
	// Clock.
	input wire logic core_clk_i,
	// Board straps and wake handshake.
	input wire logic [2:0] strap_pull_i,
	input wire logic wake_req_i,
	input wire logic sleep_indicator_i,
	output logic [2:0] straps_o,
	output logic deep_sleep_wake_o
);
	int hold_q;
	logic wake_q = 1'b0;
	// Straps are only ever pulled low or left open, so open reads one.
	assign straps_o = ~strap_pull_i;
	// Wake is held until the indicator rises, then falls to its pull-down.
	// The bound keeps a dead device from hanging the host forever.
	always @(posedge core_clk_i) begin
		if (wake_req_i && !wake_q) begin
			wake_q <= 1'b1;
			hold_q <= 0;
		end else if (wake_q) begin
			hold_q <= hold_q + 1;
			if (sleep_indicator_i === 1'b1 || hold_q > 60) begin
				wake_q <= 1'b0;
			end
		end
	end
	assign deep_sleep_wake_o = wake_q;
endmodule // host_model

// ==== tb/host_select_power_handshake_tb_top.sv ====
`timescale 1ns/1ps
module host_select_power_handshake_tb_top;
	import pin_ctrl_pkg::*;
	// Design inputs, named as the ports that they feed.
	logic core_clk_i = 0, resetn_i = 0, clk_en_i = 1;
	logic boot_loading_i = 0, loader_bypass_in_i = 0;
	logic pin_handshake_en_i = 1, pkt_sleep_req_i = 0, pkt_deep_req_i = 0;
	logic pkt_wake_i = 0, host_wake_en_i = 0, host_wake_active_high_i = 0;
	logic pkt_pending_i = 0, wlan_tx_i = 0, peer_priority_in_i = 0;
	logic peer_tx_active_in_i = 0, host_serial_rx_i = 0;
	logic host_serial_cts_i = 1, uart_tx_i = 1, uart_rts_i = 1;
	logic debug_serial_rx_i = 0, dbg_tx_i = 0, audio_bclk_i = 0;
	logic audio_ws_i = 0, audio_din_i = 0, audio_dout_i = 0;
	logic i2c_en_i = 0, i2c_scl_i = 0, i2c_sda_i = 0, i2c_sda_low_i = 0;
	logic gpio_dir_we_i = 0;
	logic [15:0] gpio_dir_wdata_i = 16'h0000;
	pin_mode_t pin_mode_i = PIN_GPIO;
	logic [2:0] straps_i, pull = 3'h0;
	logic deep_sleep_wake_in_i, wake_req = 0;
	// Design outputs.
	host_if_t host_if_o;
	logic ignore_host_o, load_default_fw_o, sleep_indicator_o;
	logic deep_sleep_indicator_o, supply_enable_out_o, light_sleep_o;
	logic deep_sleep_o, host_wake_o, radio_tx_active_out_o, tx_grant_o;
	logic host_serial_tx_o, host_serial_rts_o, uart_rx_o, uart_cts_o;
	logic debug_serial_tx_o, dbg_rx_o, audio_dout_o, audio_bclk_o;
	logic audio_ws_o, audio_din_o, i2c_scl_o, i2c_sda_o, i2c_sda_oe_o;
	logic i2c_sda_in_o;
	logic [15:0] gpio_oe_o, gpio_out_o;
	int bad_count = 0, compares = 0;
	logic [2:0] pulls [6] = '{3'h0, 3'h4, 3'h3, 3'h2, 3'h7, 3'h6};
	host_if_t modes [6] = '{HOST_SDIO, HOST_SPI, HOST_USB, HOST_USB_CDC,
		HOST_BAD, HOST_UART};

	host_select_power_handshake host_select_power_handshake_i (.*);
	host_model host_model_i (.core_clk_i(core_clk_i), .strap_pull_i(pull),
		.wake_req_i(wake_req), .sleep_indicator_i(sleep_indicator_o),
		.straps_o(straps_i), .deep_sleep_wake_o(deep_sleep_wake_in_i));

	// Free-running 125 MHz clock.
	always #4 core_clk_i = ~core_clk_i;

	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk_i);
	endtask

	task automatic chk(input string nm, input logic [15:0] e, g);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Straps settle before the release, since they are caught right after.
	task automatic do_reset(input logic [2:0] p);
		pull = p;
		resetn_i = 0;
		cyc(4);
		resetn_i = 1;
		cyc(3);
	endtask

	task automatic end_of_test;
		if (bad_count == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// The tests need a little over a hundred cycles; this cuts a hang short.
	initial begin
		#30000;
		bad_count++;
		end_of_test;
	end

	initial begin
		logic uart_on;
		logic hw_exp;
		// Six of the eight strap codes, every named host among them, with the serial pins following the choice.
		foreach (pulls[i]) begin
			do_reset(pulls[i]);
			uart_on = (modes[i] == HOST_UART);
			chk("host_if", 16'(modes[i]), 16'(host_if_o));
			chk("ser_tx", 16'(uart_on), 16'(host_serial_tx_o));
			chk("ser_rts", 16'(uart_on), 16'(host_serial_rts_o));
			chk("ser_rx", 16'(!uart_on), 16'(uart_rx_o));
			chk("ser_cts", 16'(uart_on), 16'(uart_cts_o));
		end
		// Straps moving after reset must not change the choice.
		pull = 3'h0;
		cyc(3);
		chk("host_if_held", 16'(HOST_UART), 16'(host_if_o));
		do_reset(3'h0);
		// Bypass while the loader runs.
		boot_loading_i = 1;
		loader_bypass_in_i = 1;
		cyc(2);
		chk("ignore_host", 1, ignore_host_o);
		chk("load_default", 1, load_default_fw_o);
		loader_bypass_in_i = 0;
		boot_loading_i = 0;
		// Deep sleep by packet, then woken by the host's wake pin.
		pkt_deep_req_i = 1;
		cyc(1);
		pkt_deep_req_i = 0;
		chk("deep", 1, deep_sleep_o);
		chk("ignore_off", 0, ignore_host_o);
		cyc(1);
		chk("sleep_ind", 0, sleep_indicator_o);
		chk("deep_ind", 0, deep_sleep_indicator_o);
		chk("supply", 0, supply_enable_out_o);
		cyc(5);
		chk("deep_no_wake", 1, deep_sleep_o);
		wake_req = 1;
		cyc(1);
		wake_req = 0;
		cyc(3);
		chk("deep_woke", 0, deep_sleep_o);
		chk("deep_ind_up", 1, deep_sleep_indicator_o);
		chk("supply_up", 1, supply_enable_out_o);
		chk("sleep_ind_up", 1, sleep_indicator_o);
		// Light sleep; the bypass pin only wakes once loading is done.
		pkt_sleep_req_i = 1;
		cyc(1);
		pkt_sleep_req_i = 0;
		cyc(1);
		chk("light", 1, light_sleep_o);
		chk("light_ind", 0, sleep_indicator_o);
		chk("light_deep_ind", 1, deep_sleep_indicator_o);
		boot_loading_i = 1;
		loader_bypass_in_i = 1;
		cyc(3);
		chk("light_boot", 1, light_sleep_o);
		boot_loading_i = 0;
		cyc(3);
		loader_bypass_in_i = 0;
		chk("light_woke", 0, light_sleep_o);
		chk("light_ind_up", 1, sleep_indicator_o);
		// Packet sleep and wake with the pin handshake switched off.
		pin_handshake_en_i = 0;
		pkt_sleep_req_i = 1;
		cyc(1);
		pkt_sleep_req_i = 0;
		cyc(1);
		chk("light_pkt", 1, light_sleep_o);
		chk("ind_no_hs", 1, sleep_indicator_o);
		pkt_wake_i = 1;
		cyc(1);
		pkt_wake_i = 0;
		chk("light_pkt_woke", 0, light_sleep_o);
		pkt_deep_req_i = 1;
		cyc(1);
		pkt_deep_req_i = 0;
		chk("deep_pkt", 1, deep_sleep_o);
		pkt_wake_i = 1;
		cyc(1);
		pkt_wake_i = 0;
		chk("deep_pkt_woke", 0, deep_sleep_o);
		pin_handshake_en_i = 1;
		// A low enable freezes all state, requests and writes included.
		clk_en_i = 0;
		pkt_deep_req_i = 1;
		gpio_dir_wdata_i = 16'h00ff;
		gpio_dir_we_i = 1;
		cyc(2);
		chk("frozen_deep", 0, deep_sleep_o);
		chk("frozen_gpio", 0, gpio_oe_o);
		pkt_deep_req_i = 0;
		gpio_dir_we_i = 0;
		clk_en_i = 1;
		// Host wake output over enable, polarity and pending; the host
		// turns it on only as a fallback to its interface interrupt.
		for (int i = 0; i < 8; i++) begin
			{host_wake_en_i, host_wake_active_high_i, pkt_pending_i} = 3'(i);
			hw_exp = (i[2] & i[0]) ? i[1] : !i[1];
			cyc(2);
			chk("host_wake", 16'(hw_exp), 16'(host_wake_o));
		end
		// Radio coexistence: peer activity, then peer priority.
		pin_mode_i = PIN_COEX;
		wlan_tx_i = 1;
		cyc(2);
		chk("tx_active", 1, radio_tx_active_out_o);
		chk("grant", 1, tx_grant_o);
		peer_tx_active_in_i = 1;
		cyc(2);
		chk("grant_busy", 0, tx_grant_o);
		peer_tx_active_in_i = 0;
		peer_priority_in_i = 1;
		cyc(2);
		chk("grant_peer", 0, tx_grant_o);
		wlan_tx_i = 0;
		cyc(2);
		chk("tx_idle", 0, radio_tx_active_out_o);
		// Audio slave, then the debug port on the same pins.
		pin_mode_i = PIN_AUDIO;
		{audio_bclk_i, audio_ws_i, audio_din_i, dbg_tx_i} = 4'hf;
		cyc(2);
		chk("audio_in", 3'h7,
			{audio_bclk_o, audio_ws_o, audio_din_o});
		chk("audio_out", 0, audio_dout_o);
		pin_mode_i = PIN_GPIO;
		debug_serial_rx_i = 1;
		cyc(2);
		chk("dbg_tx", 1, debug_serial_tx_o);
		chk("dbg_rx", 1, dbg_rx_o);
		chk("audio_gated", 0, audio_bclk_o);
		// Two-wire pins.
		{i2c_en_i, i2c_scl_i, i2c_sda_i, i2c_sda_low_i} = 4'hf;
		cyc(1);
		chk("scl", 1, i2c_scl_o);
		chk("sda", 2'h1, {i2c_sda_o, i2c_sda_oe_o});
		chk("sda_in", 1, i2c_sda_in_o);
		i2c_en_i = 0;
		cyc(1);
		chk("sda_off", 0, i2c_sda_oe_o);
		// Spare pins switched to output.
		gpio_dir_wdata_i = 16'ha5c3;
		gpio_dir_we_i = 1;
		cyc(1);
		gpio_dir_we_i = 0;
		cyc(1);
		chk("gpio_oe", 16'ha5c3, gpio_oe_o);
		chk("gpio_out", 0, gpio_out_o);
		end_of_test;
	end
endmodule // host_select_power_handshake_tb_top
